//--- sim/pwm_load_model.sv
// passive load on the pwm pin: integrates on-time over a window
`timescale 1ns/1ps
module pwm_load_model
(
  input wire logic clk,
  input wire logic pwm_pin,
  input wire logic window_clear,
  output logic [31:0] high_cycles
);
  // a resistive load never drives back, so it only counts high cycles
  always_ff @(posedge clk)
  begin
    if (window_clear)
      high_cycles <= 32'h0;
    else
      high_cycles <= high_cycles + {31'h0, pwm_pin};
  end
endmodule // pwm_load_model

//--- sim/testbench.sv
// self-checking bench for the buffered pwm value update
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] clock_source_select = 2'h0;
  logic center_aligned_pwm = 1'b0;
  logic background_debug_halt = 1'b0;
  logic [7:0] write_data = 8'h00;
  logic duty_write_high = 1'b0;
  logic duty_write_low = 1'b0;
  logic modulo_write_high = 1'b0;
  logic modulo_write_low = 1'b0;
  logic status_control_write = 1'b0;
  logic window_clear = 1'b0;
  logic pwm_out;
  logic [15:0] count_value;
  logic [15:0] duty_value_active;
  logic [15:0] modulo_value_active;
  logic [31:0] high_cycles;
  logic [15:0] cur_duty = 16'h0000;
  logic [15:0] top;
  logic [15:0] m;
  int fail_count = 0;
  int n_checks = 0;
  int i;

  pwm_channel_value_update uut (.clk(clk), .reset_n(reset_n),
    .clock_source_select(clock_source_select), .center_aligned_pwm(center_aligned_pwm),
    .background_debug_halt(background_debug_halt), .write_data(write_data),
    .duty_write_high(duty_write_high), .duty_write_low(duty_write_low),
    .modulo_write_high(modulo_write_high), .modulo_write_low(modulo_write_low),
    .status_control_write(status_control_write), .pwm_out(pwm_out),
    .count_value(count_value), .duty_value_active(duty_value_active),
    .modulo_value_active(modulo_value_active));
  pwm_load_model load (.clk(clk), .pwm_pin(pwm_out), .window_clear(window_clear),
    .high_cycles(high_cycles));

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic step();
    @(posedge clk);
    #2;
  endtask

  task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0d seen %0d", what, e, g);
    end
  endtask

  // idle cycle after each strobe so a strobe never rises twice in one step
  task automatic wr(input int sel, input logic [7:0] data);
    write_data = data;
    case (sel)
      0: duty_write_high = 1'b1;
      1: duty_write_low = 1'b1;
      2: modulo_write_high = 1'b1;
      3: modulo_write_low = 1'b1;
      default: status_control_write = 1'b1;
    endcase
    step();
    {duty_write_high, duty_write_low, modulo_write_high} = 3'h0;
    {modulo_write_low, status_control_write} = 2'h0;
    step();
  endtask

  task automatic wait_cnt(input logic [15:0] val);
    int n;
    for (n = 0; n < 70000 && count_value !== val; n++)
      step();
    if (count_value !== val)
    begin
      chk16("wait count", val, count_value);
      tally_and_finish();
    end
  endtask

  function automatic int exp_high(input logic c, input logic [15:0] t, input logic [15:0] d);
    if (!c)
      return (d > t) ? int'(t) + 1 : int'(d);
    if (d == 16'h0000)
      return 0;
    return (d >= t) ? 2 * int'(t) : 2 * int'(d) - 1;
  endfunction

  task automatic set_mod(input logic [15:0] v);
    wr(2, v[15:8]);
    wr(3, v[7:0]);
    chk16("modulo", v, modulo_value_active);
    top = (v == 16'h0000 || v == 16'hFFFF) ? 16'hFFFF : v;
  endtask

  // writes start at count 1 so the pair is complete well before the load edge
  task automatic load_duty(input logic [15:0] d);
    int n;
    wait_cnt(16'h0001);
    wr(0, d[15:8]);
    wr(1, d[7:0]);
    for (n = 0; n < 200 && count_value !== top; n++)
    begin
      chk16("duty held", cur_duty, duty_value_active);
      step();
    end
    wait_cnt(top);
    chk16("duty loaded", d, duty_value_active);
    cur_duty = d;
  endtask

  task automatic measure(input logic c, input logic [15:0] d);
    int per;
    per = c ? 2 * int'(top) : int'(top) + 1;
    wait_cnt(16'h0000);
    step();
    wait_cnt(16'h0000);
    window_clear = 1'b1;
    step();
    window_clear = 1'b0;
    repeat (per) step();
    chk32("high cycles", 32'(exp_high(c, top, d)), high_cycles);
  endtask

  task automatic run_case(input logic c, input logic [15:0] mv, input logic [15:0] d);
    center_aligned_pwm = c;
    set_mod(mv);
    load_duty(d);
    measure(c, d);
  endtask

  task automatic half_after_load(input logic [15:0] d, input logic exp_seen);
    logic s;
    int n;
    s = 1'b0;
    load_duty(d);
    for (n = 0; n < 100 && count_value !== 16'h0000; n++)
    begin
      step();
      s = s | pwm_out;
    end
    chk32("old duty rest of period", {31'h0, exp_seen}, {31'h0, s});
    measure(1'b1, d);
  endtask

  initial
  begin
    i = $urandom(32'h9A38ACA2);
    repeat (2) @(posedge clk);
    #2;
    reset_n = 1'b1;
    chk16("reset count", 16'h0000, count_value);
    chk16("reset duty", 16'h0000, duty_value_active);
    chk16("reset modulo", 16'h0000, modulo_value_active);
    chk32("reset pwm", 32'h0, {31'h0, pwm_out});
    repeat (3) step();
    chk16("count without clock source", 16'h0000, count_value);
    clock_source_select = 2'(1 + $urandom % 3);
    run_case(1'b0, 16'h0010, 16'h0006);
    wr(1, 8'h02);
    repeat (40) step();
    chk16("single byte not loaded", 16'h0006, duty_value_active);
    run_case(1'b0, 16'h000C, 16'h000D);
    run_case(1'b1, 16'h000A, 16'h000A);
    run_case(1'b1, 16'h000A, 16'h0009);
    half_after_load(16'h0000, 1'b1);
    half_after_load(16'h0004, 1'b0);
    for (i = 0; i < 6; i++)
    begin
      m = 16'(8 + $urandom % 25);
      run_case(i[0], m, 16'($urandom % (m + 2)));
    end
    center_aligned_pwm = 1'b1;
    wait_cnt(top);
    step();
    chk16("count after peak", top - 16'h0001, count_value);
    background_debug_halt = 1'b1;
    m = count_value;
    repeat (3) step();
    chk16("halted count", m, count_value);
    m = modulo_value_active;
    wr(2, 8'h12);
    wr(4, 8'h00);
    wr(3, 8'h34);
    chk16("modulo pair cleared", m, modulo_value_active);
    wr(2, 8'h00);
    chk16("modulo new pair", 16'h0034, modulo_value_active);
    background_debug_halt = 1'b0;
    center_aligned_pwm = 1'b0;
    set_mod(16'hFFFF);
    wait_cnt(16'h0200);
    set_mod(16'h0000);
    wait_cnt(16'hFFFF);
    step();
    chk16("free run wrap", 16'h0000, count_value);
    tally_and_finish();
  end
endmodule // testbench

//--- src/pwm_channel_value_update.sv
// pwm timer with buffered duty and modulo values, one channel
`timescale 1ns/1ps
module pwm_channel_value_update
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] clock_source_select,
  input wire logic center_aligned_pwm,
  input wire logic background_debug_halt,
  input wire logic [7:0] write_data,
  input wire logic duty_write_high,
  input wire logic duty_write_low,
  input wire logic modulo_write_high,
  input wire logic modulo_write_low,
  input wire logic status_control_write,
  output logic pwm_out,
  output logic [15:0] count_value,
  output logic [15:0] duty_value_active,
  output logic [15:0] modulo_value_active
);
  // counter group
  logic [15:0] count_reg;
  logic [15:0] count_next;
  pwm_value_pkg::count_dir_t dir_reg;
  pwm_value_pkg::count_dir_t dir_next;
  logic [15:0] top;
  logic [15:0] top_minus_one;
  logic advance;
  logic load_event;

  // duty buffer group
  logic [7:0] duty_buf_high_reg;
  logic [7:0] duty_buf_high_next;
  logic [7:0] duty_buf_low_reg;
  logic [7:0] duty_buf_low_next;
  logic duty_high_seen_reg;
  logic duty_high_seen_next;
  logic duty_low_seen_reg;
  logic duty_low_seen_next;
  logic [15:0] duty_reg;
  logic [15:0] duty_next;

  // modulo buffer group
  logic [7:0] mod_buf_high_reg;
  logic [7:0] mod_buf_high_next;
  logic [7:0] mod_buf_low_reg;
  logic [7:0] mod_buf_low_next;
  logic mod_high_seen_reg;
  logic mod_high_seen_next;
  logic mod_low_seen_reg;
  logic mod_low_seen_next;
  logic [15:0] mod_reg;
  logic [15:0] mod_next;

  always_comb
  begin
    top = pwm_value_pkg::count_top(mod_reg);
    top_minus_one = top - pwm_value_pkg::VAL_ONE;
    // prescaler is not modelled; the counter steps on every clock while a source is on and background_debug_halt is low
    advance = (clock_source_select != pwm_value_pkg::CLKSRC_OFF) && !background_debug_halt;
    load_event = advance && dir_reg == pwm_value_pkg::DIR_UP && count_reg == top_minus_one;
    count_next = count_reg;
    dir_next = dir_reg;
    if (advance)
    begin
      if (dir_reg == pwm_value_pkg::DIR_UP)
      begin
        if (count_reg >= top)
        begin
          if (center_aligned_pwm)
          begin
            dir_next = pwm_value_pkg::DIR_DOWN;
            count_next = count_reg - pwm_value_pkg::VAL_ONE;
          end
          else
          begin
            count_next = pwm_value_pkg::VAL_ZERO;
          end
        end
        else
        begin
          count_next = count_reg + pwm_value_pkg::VAL_ONE;
        end
      end
      else if (count_reg == pwm_value_pkg::VAL_ZERO || !center_aligned_pwm)
      begin
        // leaving center mode mid-descent resumes up counting from here
        dir_next = pwm_value_pkg::DIR_UP;
        count_next = count_reg + pwm_value_pkg::VAL_ONE;
      end
      else
      begin
        count_next = count_reg - pwm_value_pkg::VAL_ONE;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      count_reg <= pwm_value_pkg::VAL_ZERO;
      dir_reg <= pwm_value_pkg::DIR_UP;
    end
    else
    begin
      count_reg <= count_next;
      dir_reg <= dir_next;
    end
  end

  always_comb
  begin
    duty_buf_high_next = duty_buf_high_reg;
    duty_buf_low_next = duty_buf_low_reg;
    duty_high_seen_next = duty_high_seen_reg;
    duty_low_seen_next = duty_low_seen_reg;
    duty_next = duty_reg;
    // a load in the same cycle as a byte write consumes the old pair; the new byte stays pending
    if (load_event && duty_high_seen_reg && duty_low_seen_reg)
    begin
      duty_next = {duty_buf_high_reg, duty_buf_low_reg};
      duty_high_seen_next = 1'b0;
      duty_low_seen_next = 1'b0;
    end
    if (duty_write_high)
    begin
      duty_buf_high_next = write_data;
      duty_high_seen_next = 1'b1;
    end
    if (duty_write_low)
    begin
      duty_buf_low_next = write_data;
      duty_low_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      duty_buf_high_reg <= pwm_value_pkg::BYTE_ZERO;
      duty_buf_low_reg <= pwm_value_pkg::BYTE_ZERO;
      duty_high_seen_reg <= 1'b0;
      duty_low_seen_reg <= 1'b0;
      duty_reg <= pwm_value_pkg::VAL_ZERO;
    end
    else
    begin
      duty_buf_high_reg <= duty_buf_high_next;
      duty_buf_low_reg <= duty_buf_low_next;
      duty_high_seen_reg <= duty_high_seen_next;
      duty_low_seen_reg <= duty_low_seen_next;
      duty_reg <= duty_next;
    end
  end

  always_comb
  begin
    mod_buf_high_next = mod_buf_high_reg;
    mod_buf_low_next = mod_buf_low_reg;
    mod_high_seen_next = mod_high_seen_reg;
    mod_low_seen_next = mod_low_seen_reg;
    mod_next = mod_reg;
    if (modulo_write_high)
    begin
      mod_buf_high_next = write_data;
      mod_high_seen_next = 1'b1;
    end
    if (modulo_write_low)
    begin
      mod_buf_low_next = write_data;
      mod_low_seen_next = 1'b1;
    end
    // both bytes are buffered so the pair completes correctly in either order
    if (mod_high_seen_next && mod_low_seen_next)
    begin
      mod_next = {mod_buf_high_next, mod_buf_low_next};
      mod_high_seen_next = 1'b0;
      mod_low_seen_next = 1'b0;
    end
    if (background_debug_halt && status_control_write)
    begin
      mod_high_seen_next = 1'b0;
      mod_low_seen_next = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mod_buf_high_reg <= pwm_value_pkg::BYTE_ZERO;
      mod_buf_low_reg <= pwm_value_pkg::BYTE_ZERO;
      mod_high_seen_reg <= 1'b0;
      mod_low_seen_reg <= 1'b0;
      mod_reg <= pwm_value_pkg::VAL_ZERO;
    end
    else
    begin
      mod_buf_high_reg <= mod_buf_high_next;
      mod_buf_low_reg <= mod_buf_low_next;
      mod_high_seen_reg <= mod_high_seen_next;
      mod_low_seen_reg <= mod_low_seen_next;
      mod_reg <= mod_next;
    end
  end

  assign count_value = count_reg;
  assign duty_value_active = duty_reg;
  assign modulo_value_active = mod_reg;

  pwm_out_stage u_out
  (
    .clk(clk),
    .reset_n(reset_n),
    .center_aligned_pwm(center_aligned_pwm),
    .count(count_reg),
    .top(top),
    .duty(duty_reg),
    .pwm_out(pwm_out)
  );

  property p_edge_load;
    @(posedge clk) disable iff (!reset_n)
    !center_aligned_pwm && $changed(duty_reg) |-> $past(load_event) && $past(duty_low_seen_reg);
  endproperty
  a_edge_load: assert property (p_edge_load) else $error("edge duty loaded off event");

  property p_center_load;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && $changed(duty_reg)
      |-> $past(load_event) && $past(duty_high_seen_reg)
      && $past(count_reg) == $past(top_minus_one);
  endproperty
  a_center_load: assert property (p_center_load) else $error("center duty loaded off event");

  property p_debug_clear;
    @(posedge clk) disable iff (!reset_n)
    background_debug_halt && status_control_write |=> !mod_high_seen_reg && !mod_low_seen_reg;
  endproperty
  a_debug_clear: assert property (p_debug_clear) else $error("modulo tracking not cleared");

  property p_free_run;
    @(posedge clk) disable iff (!reset_n)
    !center_aligned_pwm && advance && mod_reg == pwm_value_pkg::VAL_ZERO
      && count_reg == pwm_value_pkg::VAL_ONES |=> count_reg == pwm_value_pkg::VAL_ZERO;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free run wrap wrong");

  property p_turn_down;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && advance && dir_reg == pwm_value_pkg::DIR_UP && count_reg == top
      && top != pwm_value_pkg::VAL_ZERO |=> dir_reg == pwm_value_pkg::DIR_DOWN;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("center count did not turn");

  property p_edge_wrap;
    @(posedge clk) disable iff (!reset_n)
    !center_aligned_pwm && advance && dir_reg == pwm_value_pkg::DIR_UP && count_reg == top
      |=> count_reg == pwm_value_pkg::VAL_ZERO;
  endproperty
  a_edge_wrap: assert property (p_edge_wrap) else $error("edge period wrong");

  c_load: cover property (@(posedge clk) load_event && duty_high_seen_reg && duty_low_seen_reg);
  c_debug: cover property (@(posedge clk) background_debug_halt && status_control_write);
  c_center_turn: cover property (@(posedge clk)
    center_aligned_pwm && dir_reg == pwm_value_pkg::DIR_DOWN);
endmodule // pwm_channel_value_update

//--- src/pwm_out_stage.sv
// compare stage: latches the duty per period and forms the pwm output
`timescale 1ns/1ps
module pwm_out_stage
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic center_aligned_pwm,
  input wire logic [15:0] count,
  input wire logic [15:0] top,
  input wire logic [15:0] duty,
  output logic pwm_out
);
  logic [15:0] period_duty_reg;
  logic [15:0] period_duty_next;
  logic pwm_out_next;
  logic [15:0] duty_sel;
  logic [15:0] top_minus_one;

  always_comb
  begin
    top_minus_one = top - pwm_value_pkg::VAL_ONE;
    // the duty in force is sampled only at count zero, so a new value never cuts a period short
    duty_sel = (count == pwm_value_pkg::VAL_ZERO) ? duty : period_duty_reg;
    period_duty_next = duty_sel;
    // below the duty value the output is active; dropping below it on the way down turns it on
    // and matching on the way up turns it off, which is the same compare seen both ways
    pwm_out_next = (count < duty_sel);
    if (center_aligned_pwm && duty_sel == top)
    begin
      pwm_out_next = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      period_duty_reg <= pwm_value_pkg::VAL_ZERO;
      pwm_out <= 1'b0;
    end
    else
    begin
      period_duty_reg <= period_duty_next;
      pwm_out <= pwm_out_next;
    end
  end

  property p_full_duty;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && duty_sel == top |=> pwm_out;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty output not active");

  property p_near_full;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && duty_sel == top_minus_one && count < top_minus_one |=> pwm_out;
  endproperty
  a_near_full: assert property (p_near_full) else $error("near full duty output dropped");

  property p_period_latch;
    @(posedge clk) disable iff (!reset_n)
    $changed(period_duty_reg) |-> $past(count) == pwm_value_pkg::VAL_ZERO;
  endproperty
  a_period_latch: assert property (p_period_latch) else $error("duty changed mid period");

  property p_zero_duty;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && duty_sel == pwm_value_pkg::VAL_ZERO && top != pwm_value_pkg::VAL_ZERO
      |=> !pwm_out;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty output active");

  property p_up_match_off;
    @(posedge clk) disable iff (!reset_n)
    center_aligned_pwm && count == duty_sel && duty_sel != top |=> !pwm_out;
  endproperty
  a_up_match_off: assert property (p_up_match_off) else $error("match did not end pulse");

  c_full_duty: cover property (@(posedge clk) center_aligned_pwm && duty_sel == top);
endmodule // pwm_out_stage

//--- src/pwm_value_pkg.sv
// shared constants and types for the buffered pwm channel value update block
// Summary of operation
// - In edge-aligned mode with a clock source selected, a buffered duty value reaches the active compare value only after both bytes are written and the counter steps from modulo minus one to modulo.
// - In center-aligned mode with a clock source selected, the buffered duty value is loaded only after both bytes are written and the counter steps from modulo minus one to modulo.
// - In center-aligned mode a duty value equal to the modulo value keeps the output active for the whole period.
// - In center-aligned mode a duty value of modulo minus one gives an output active for nearly the whole period.
// - In center-aligned mode a change of duty from zero to non-zero takes effect only when a new period begins.
// - In center-aligned mode a change of duty from non-zero to zero finishes the current period with the old duty.
// - While halted for background debug, a status/control write clears the partial-write tracking of the modulo value.
// - A modulo value of all zeros or all ones means no limit, so the counter runs through its full range.
// - In center-aligned mode the counter runs up to the modulo value then down to zero, a period of twice the modulo.
// - In center-aligned mode the output turns active on a match while counting down and inactive on a match while counting up.
//   This block turns it active one count after the down match, once the count is below the duty value.
// - In edge-aligned mode the period is the modulo value plus one and the duty value sets the transition point.
package pwm_value_pkg;
  localparam int CNT_W = 16;
  localparam logic [15:0] VAL_ZERO = 16'h0000;
  localparam logic [15:0] VAL_ONES = 16'hFFFF;
  localparam logic [15:0] VAL_ONE = 16'h0001;
  localparam logic [1:0] CLKSRC_OFF = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic
  {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

  // effective top of count: zero and all ones both mean free running
  function automatic logic [15:0] count_top(input logic [15:0] modulo);
    count_top = (modulo == VAL_ZERO || modulo == VAL_ONES) ? VAL_ONES : modulo;
  endfunction
endpackage
